// ==== rtl/dio_pkg.sv ====
// Constants for the dual 8-bit I/O port pair.
// Assumes a plain register port with byte-wide data and one-cycle strobes.
package dio_pkg;
   localparam int DIO_ADDR_W = 3;
   localparam int DIO_DATA_W = 8;
   // Register offsets; direction shares the pin-level offset
   localparam logic [2:0] DIO_C_PIN_LEVEL_OFS = 3'h0;
   localparam logic [2:0] DIO_C_OUTPUT_VALUE_OFS = 3'h1;
   localparam logic [2:0] DIO_C_DRIVER_TYPE_OFS = 3'h2;
   localparam logic [2:0] DIO_D_PIN_LEVEL_OFS = 3'h4;
   localparam logic [2:0] DIO_D_OUTPUT_VALUE_OFS = 3'h5;
   localparam logic [2:0] DIO_D_DRIVER_TYPE_OFS = 3'h6;
   localparam logic [7:0] DIO_DIRECTION_RST = 8'h00;
   localparam logic [7:0] DIO_OUTPUT_VALUE_RST = 8'h00;
   localparam logic [7:0] DIO_DRIVER_TYPE_RST = 8'h00;
   localparam logic [7:0] DIO_UNMAPPED_READ = 8'h00;
endpackage

// ==== rtl/dio_port_pair.sv ====
// Two 8-bit general-purpose ports with per-bit driver and pull-up control.
// Assumes pins arrive asynchronously; pad driver enables are decoded here.
//
// Functional notes
// - Two independent eight-bit ports, per-bit control.
// - Direction bit 0 input, 1 output; reset 0.
// - Direction write-only; its address reads pins.
// - Output value resets zero, always read/write.
// - Pin-level read returns live pin levels.
// - Write to pin-level address sets direction.
// - Pin level has no fixed reset value.
// - Driver type read/write, reset 0, CMOS.
// - Open drain: P off, N on for 0.
// - Driver type matters only for output pins.
// - Pull-up enabled per pin by software.
// - Pull-up on when direction 0, value 1.
// - Pull-ups off in reset and hardware standby.
`timescale 1ns/10ps
module dio_port_pair #(
   parameter int NUM_BITS = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [dio_pkg::DIO_ADDR_W-1:0] reg_addr,
   input wire logic [dio_pkg::DIO_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [dio_pkg::DIO_DATA_W-1:0] reg_rdata,
   input wire logic hw_standby,
   input wire logic [NUM_BITS-1:0] port_c_pin_in,
   input wire logic [NUM_BITS-1:0] port_d_pin_in,
   output logic [NUM_BITS-1:0] port_c_pch_on,
   output logic [NUM_BITS-1:0] port_c_nch_on,
   output logic [NUM_BITS-1:0] port_c_pullup_on,
   output logic [NUM_BITS-1:0] port_d_pch_on,
   output logic [NUM_BITS-1:0] port_d_nch_on,
   output logic [NUM_BITS-1:0] port_d_pullup_on
);
   import dio_pkg::*;

   logic [NUM_BITS-1:0] c_dir_reg, c_dir_next, d_dir_reg, d_dir_next;
   logic [NUM_BITS-1:0] c_val_reg, c_val_next, d_val_reg, d_val_next;
   logic [NUM_BITS-1:0] c_typ_reg, c_typ_next, d_typ_reg, d_typ_next;
   logic [NUM_BITS-1:0] c_sync1_reg, c_sync2_reg, d_sync1_reg, d_sync2_reg;
   logic [DIO_DATA_W-1:0] rdata_reg, rdata_next;
   logic hw_stby1_reg, hw_stby2_reg;
   logic in_reset_reg;

   always_comb begin
      c_dir_next = c_dir_reg;
      d_dir_next = d_dir_reg;
      c_val_next = c_val_reg;
      d_val_next = d_val_reg;
      c_typ_next = c_typ_reg;
      d_typ_next = d_typ_reg;
      if (reg_write) begin
         case (reg_addr)
            DIO_C_PIN_LEVEL_OFS: c_dir_next = reg_wdata[NUM_BITS-1:0];
            DIO_D_PIN_LEVEL_OFS: d_dir_next = reg_wdata[NUM_BITS-1:0];
            DIO_C_OUTPUT_VALUE_OFS: c_val_next = reg_wdata[NUM_BITS-1:0];
            DIO_D_OUTPUT_VALUE_OFS: d_val_next = reg_wdata[NUM_BITS-1:0];
            DIO_C_DRIVER_TYPE_OFS: c_typ_next = reg_wdata[NUM_BITS-1:0];
            DIO_D_DRIVER_TYPE_OFS: d_typ_next = reg_wdata[NUM_BITS-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         c_dir_reg <= DIO_DIRECTION_RST[NUM_BITS-1:0];
         d_dir_reg <= DIO_DIRECTION_RST[NUM_BITS-1:0];
         c_val_reg <= DIO_OUTPUT_VALUE_RST[NUM_BITS-1:0];
         d_val_reg <= DIO_OUTPUT_VALUE_RST[NUM_BITS-1:0];
         c_typ_reg <= DIO_DRIVER_TYPE_RST[NUM_BITS-1:0];
         d_typ_reg <= DIO_DRIVER_TYPE_RST[NUM_BITS-1:0];
      end else begin
         c_dir_reg <= c_dir_next;
         d_dir_reg <= d_dir_next;
         c_val_reg <= c_val_next;
         d_val_reg <= d_val_next;
         c_typ_reg <= c_typ_next;
         d_typ_reg <= d_typ_next;
      end
   end

   // Pins synchronised, no fixed reset value
   always_ff @(posedge clock) begin
      c_sync1_reg <= port_c_pin_in;
      c_sync2_reg <= c_sync1_reg;
      d_sync1_reg <= port_d_pin_in;
      d_sync2_reg <= d_sync1_reg;
   end

   // Standby is a pin; reset flag masks pull-ups until first clocked edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hw_stby1_reg <= 1'b1;
         hw_stby2_reg <= 1'b1;
         in_reset_reg <= 1'b1;
      end else begin
         hw_stby1_reg <= hw_standby;
         hw_stby2_reg <= hw_stby1_reg;
         in_reset_reg <= 1'b0;
      end
   end

   always_comb begin
      rdata_next = DIO_UNMAPPED_READ;
      if (reg_read) begin
         case (reg_addr)
            DIO_C_PIN_LEVEL_OFS: rdata_next[NUM_BITS-1:0] = c_sync2_reg;
            DIO_D_PIN_LEVEL_OFS: rdata_next[NUM_BITS-1:0] = d_sync2_reg;
            DIO_C_OUTPUT_VALUE_OFS: rdata_next[NUM_BITS-1:0] = c_val_reg;
            DIO_D_OUTPUT_VALUE_OFS: rdata_next[NUM_BITS-1:0] = d_val_reg;
            DIO_C_DRIVER_TYPE_OFS: rdata_next[NUM_BITS-1:0] = c_typ_reg;
            DIO_D_DRIVER_TYPE_OFS: rdata_next[NUM_BITS-1:0] = d_typ_reg;
            default: rdata_next = DIO_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= DIO_UNMAPPED_READ;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // Driver decode is combinational so a direction change acts at once
   for (genvar i = 0; i < NUM_BITS; i++) begin : g_bit
      always_comb begin
         port_c_pch_on[i] = 1'b0;
         port_c_nch_on[i] = 1'b0;
         port_d_pch_on[i] = 1'b0;
         port_d_nch_on[i] = 1'b0;
         if (c_dir_reg[i]) begin
            // CMOS complementary drive open drain blocks P
            port_c_pch_on[i] = c_val_reg[i] & ~c_typ_reg[i];
            port_c_nch_on[i] = ~c_val_reg[i];
         end
         if (d_dir_reg[i]) begin
            port_d_pch_on[i] = d_val_reg[i] & ~d_typ_reg[i];
            port_d_nch_on[i] = ~d_val_reg[i];
         end
         // Per-pin pull-up input and value one forced off
         port_c_pullup_on[i] = ~c_dir_reg[i] & c_val_reg[i] & resetn
            & ~in_reset_reg & ~hw_stby2_reg;
         port_d_pullup_on[i] = ~d_dir_reg[i] & d_val_reg[i] & resetn
            & ~in_reset_reg & ~hw_stby2_reg;
      end
   end

   chk_read_pins: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_C_PIN_LEVEL_OFS |=> reg_rdata == $past(c_sync2_reg))
      else $error("pin level read wrong");
   chk_dir_write: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_D_PIN_LEVEL_OFS |=> d_dir_reg == $past(reg_wdata))
      else $error("direction write lost");
   chk_value_read: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_C_OUTPUT_VALUE_OFS |=> reg_rdata == $past(c_val_reg))
      else $error("output value read wrong");
   chk_type_read: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_D_DRIVER_TYPE_OFS |=> reg_rdata == $past(d_typ_reg))
      else $error("driver type read wrong");
   chk_open_drain: assert property (@(posedge clock) disable iff (!resetn)
      (c_typ_reg & c_dir_reg) != 0 |-> (port_c_pch_on & c_typ_reg) == 0)
      else $error("p driver on in open drain");
   chk_input_float: assert property (@(posedge clock) disable iff (!resetn)
      ((port_d_pch_on | port_d_nch_on) & ~d_dir_reg) == 0)
      else $error("input pin driven");
   chk_cmos_drive: assert property (@(posedge clock) disable iff (!resetn)
      port_c_nch_on == (c_dir_reg & ~c_val_reg)
      && (port_c_pch_on & port_c_nch_on) == 0)
      else $error("cmos drive wrong");
   chk_pullup_rule: assert property (@(posedge clock) disable iff (!resetn)
      !hw_stby2_reg && !in_reset_reg |-> port_c_pullup_on == (~c_dir_reg & c_val_reg))
      else $error("pull-up mismatch");
   chk_standby_off: assert property (@(posedge clock) disable iff (!resetn)
      hw_stby2_reg |-> port_c_pullup_on == 0 && port_d_pullup_on == 0)
      else $error("pull-up on in standby");
   chk_dir_hidden: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_D_PIN_LEVEL_OFS |=> reg_rdata == $past(d_sync2_reg))
      else $error("direction leaked on read");

   // Register writes land one edge after the strobe
   chk_dir_write_c: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_C_PIN_LEVEL_OFS |=> c_dir_reg == $past(reg_wdata))
      else $error("port c direction write lost");
   chk_val_write_c: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_C_OUTPUT_VALUE_OFS |=> c_val_reg == $past(reg_wdata))
      else $error("port c value write lost");
   chk_val_write_d: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_D_OUTPUT_VALUE_OFS |=> d_val_reg == $past(reg_wdata))
      else $error("port d value write lost");
   chk_type_write_c: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_C_DRIVER_TYPE_OFS |=> c_typ_reg == $past(reg_wdata))
      else $error("port c type write lost");
   chk_type_write_d: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_D_DRIVER_TYPE_OFS |=> d_typ_reg == $past(reg_wdata))
      else $error("port d type write lost");

   // Registers hold unless their own offset is written
   chk_dir_hold_c: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_C_PIN_LEVEL_OFS) |=> $stable(c_dir_reg))
      else $error("port c direction changed");
   chk_dir_hold_d: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_D_PIN_LEVEL_OFS) |=> $stable(d_dir_reg))
      else $error("port d direction changed");
   chk_val_hold_c: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_C_OUTPUT_VALUE_OFS) |=> $stable(c_val_reg))
      else $error("port c value changed");
   chk_val_hold_d: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_D_OUTPUT_VALUE_OFS) |=> $stable(d_val_reg))
      else $error("port d value changed");
   chk_type_hold_c: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_C_DRIVER_TYPE_OFS) |=> $stable(c_typ_reg))
      else $error("port c type changed");
   chk_type_hold_d: assert property (@(posedge clock) disable iff (!resetn)
      !(reg_write && reg_addr == DIO_D_DRIVER_TYPE_OFS) |=> $stable(d_typ_reg))
      else $error("port d type changed");
   chk_pin_nowrite_c: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_C_PIN_LEVEL_OFS |=> $stable(c_val_reg) && $stable(c_typ_reg))
      else $error("port c pin write leaked");
   chk_pin_nowrite_d: assert property (@(posedge clock) disable iff (!resetn)
      reg_write && reg_addr == DIO_D_PIN_LEVEL_OFS |=> $stable(d_val_reg) && $stable(d_typ_reg))
      else $error("port d pin write leaked");

   // Read side
   chk_value_read_d: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_D_OUTPUT_VALUE_OFS |=> reg_rdata == $past(d_val_reg))
      else $error("port d value read wrong");
   chk_type_read_c: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == DIO_C_DRIVER_TYPE_OFS |=> reg_rdata == $past(c_typ_reg))
      else $error("port c type read wrong");
   chk_unmapped_read: assert property (@(posedge clock) disable iff (!resetn)
      reg_read && (reg_addr == 3'h3 || reg_addr == 3'h7) |=> reg_rdata == DIO_UNMAPPED_READ)
      else $error("unmapped read not zero");
   chk_rdata_idle: assert property (@(posedge clock) disable iff (!resetn)
      !reg_read |=> reg_rdata == DIO_UNMAPPED_READ)
      else $error("read data outside read cycle");
   chk_pin_sync_c: assert property (@(posedge clock) disable iff (!resetn)
      c_sync2_reg == $past(port_c_pin_in, 2))
      else $error("port c pin sync wrong");
   chk_pin_sync_d: assert property (@(posedge clock) disable iff (!resetn)
      d_sync2_reg == $past(port_d_pin_in, 2))
      else $error("port d pin sync wrong");

   // Driver decode, port by port
   chk_open_drain_d: assert property (@(posedge clock) disable iff (!resetn)
      (port_d_pch_on & d_typ_reg) == 0)
      else $error("port d p driver on in open drain");
   chk_od_nch_c: assert property (@(posedge clock) disable iff (!resetn)
      (port_c_nch_on & c_typ_reg) == (c_typ_reg & c_dir_reg & ~c_val_reg))
      else $error("port c open drain n driver wrong");
   chk_od_nch_d: assert property (@(posedge clock) disable iff (!resetn)
      (port_d_nch_on & d_typ_reg) == (d_typ_reg & d_dir_reg & ~d_val_reg))
      else $error("port d open drain n driver wrong");
   chk_input_float_c: assert property (@(posedge clock) disable iff (!resetn)
      ((port_c_pch_on | port_c_nch_on) & ~c_dir_reg) == 0)
      else $error("port c input pin driven");
   chk_cmos_drive_d: assert property (@(posedge clock) disable iff (!resetn)
      port_d_nch_on == (d_dir_reg & ~d_val_reg))
      else $error("port d n driver wrong");
   chk_cmos_pch_c: assert property (@(posedge clock) disable iff (!resetn)
      port_c_pch_on == (c_dir_reg & c_val_reg & ~c_typ_reg))
      else $error("port c p driver wrong");
   chk_cmos_pch_d: assert property (@(posedge clock) disable iff (!resetn)
      port_d_pch_on == (d_dir_reg & d_val_reg & ~d_typ_reg))
      else $error("port d p driver wrong");
   chk_no_dual_d: assert property (@(posedge clock) disable iff (!resetn)
      (port_d_pch_on & port_d_nch_on) == 0)
      else $error("port d both drivers on");

   // Pull-up decode
   chk_pullup_rule_d: assert property (@(posedge clock) disable iff (!resetn)
      !hw_stby2_reg && !in_reset_reg |-> port_d_pullup_on == (~d_dir_reg & d_val_reg))
      else $error("port d pull-up mismatch");
   chk_pullup_out_c: assert property (@(posedge clock) disable iff (!resetn)
      (port_c_pullup_on & c_dir_reg) == 0)
      else $error("port c pull-up on output");
   chk_pullup_out_d: assert property (@(posedge clock) disable iff (!resetn)
      (port_d_pullup_on & d_dir_reg) == 0)
      else $error("port d pull-up on output");
   chk_first_edge: assert property (@(posedge clock) disable iff (!resetn)
      in_reset_reg |-> port_c_pullup_on == 0 && port_d_pullup_on == 0)
      else $error("pull-up on right after reset");

   // Held in reset: no disable, these watch the reset itself
   chk_reset_regs: assert property (@(posedge clock)
      !resetn |-> c_dir_reg == 0 && d_dir_reg == 0 && c_val_reg == 0
      && d_val_reg == 0 && c_typ_reg == 0 && d_typ_reg == 0)
      else $error("register not zero in reset");
   chk_reset_pullup: assert property (@(posedge clock)
      !resetn |-> port_c_pullup_on == 0 && port_d_pullup_on == 0)
      else $error("pull-up on in reset");
   chk_reset_drivers: assert property (@(posedge clock)
      !resetn |-> (port_c_pch_on | port_c_nch_on | port_d_pch_on | port_d_nch_on) == 0)
      else $error("driver on in reset");
   chk_reset_rdata: assert property (@(posedge clock)
      !resetn |-> reg_rdata == DIO_UNMAPPED_READ)
      else $error("read data not zero in reset");
endmodule

// ==== test/dio_pin_model.sv ====
// Board-side model of the eight pins of one port.
// Assumes the bench plays any other device driving the pins.
`timescale 1ns/10ps
module dio_pin_model (
   input wire logic clock,
   input wire logic [7:0] pch_on,
   input wire logic [7:0] nch_on,
   input wire logic [7:0] pullup_on,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_level
);
   logic [7:0] float_reg = 8'h5a;
   // Undriven pins wander, so a stale level never passes for a real one
   always @(posedge clock) float_reg <= ~float_reg;
   assign pin_level = ~nch_on & (pch_on | ext_en & ext_val | ~ext_en & (pullup_on | float_reg));
endmodule

// ==== test/dio_port_pair_tb.sv ====
// Self-checking bench for the dual port pair.
// Assumes a pin model on each port; reads are checked from a queue.
`timescale 1ns/10ps
module dio_port_pair_tb;
   import dio_pkg::*;
   logic clock, resetn, reg_write, reg_read, hw_standby, rd_q, sb;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [7:0] pin_w [2], pch_w [2], nch_w [2], pu_w [2], ev [2], ee [2];
   logic [7:0] dir [2], odr [2], typ [2];
   logic [15:0] note;
   logic [15:0] note_q [$];
   int n_fail, checks;
   dio_port_pair dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .hw_standby(hw_standby), .port_c_pin_in(pin_w[0]),
      .port_d_pin_in(pin_w[1]), .port_c_pch_on(pch_w[0]), .port_c_nch_on(nch_w[0]),
      .port_c_pullup_on(pu_w[0]), .port_d_pch_on(pch_w[1]), .port_d_nch_on(nch_w[1]),
      .port_d_pullup_on(pu_w[1]));
   for (genvar g = 0; g < 2; g++) begin : pins
      dio_pin_model pm_u (.clock(clock), .pch_on(pch_w[g]), .nch_on(nch_w[g]),
         .pullup_on(pu_w[g]), .ext_val(ev[g]), .ext_en(ee[g]), .pin_level(pin_w[g]));
   end
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      checks++;
      if ((got & m) !== (exp & m)) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   always @(posedge clock) begin
      if (rd_q) begin
         note = note_q.pop_front();
         chk(reg_rdata, note[7:0], note[15:8]);
      end
      rd_q <= reg_read;
   end
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= w;
      reg_read <= ~w;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] n);
      note_q.push_back(n);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic idle(input int n);
      @(posedge clock);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   function automatic logic [15:0] pin_note(input int p);
      logic [7:0] n, u, h;
      n = dir[p] & ~odr[p];
      h = dir[p] & odr[p] & ~typ[p];
      u = sb ? 8'h00 : ~dir[p] & odr[p];
      return {n | h | ee[p] | u, ~n & (h | ee[p] & ev[p] | ~ee[p] & u)};
   endfunction
   task automatic chk_pins;
      @(negedge clock);
      for (int p = 0; p < 2; p++) begin
         chk(nch_w[p], dir[p] & ~odr[p], 8'hff);
         chk(pch_w[p], dir[p] & odr[p] & ~typ[p], 8'hff);
         chk(pu_w[p], sb ? 8'h00 : ~dir[p] & odr[p], 8'hff);
      end
   endtask
   task automatic give_verdict;
      // Every read noted must have been answered
      if (note_q.size() != 0) n_fail++;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      give_verdict();
   end
   initial begin
      {resetn, reg_write, reg_read, hw_standby, rd_q, sb} = 6'h01;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      for (int p = 0; p < 2; p++) begin
         {dir[p], odr[p], typ[p], ev[p], ee[p]} = {24'h0, 8'ha5, 8'hff};
      end
      void'($urandom(32'h8070491f));
      repeat (6) @(posedge clock);
      chk_pins();
      @(posedge clock);
      resetn <= 1'b1;
      sb = 1'b0;
      bus(1'b1, 3'h3, 8'hff);
      bus(1'b1, 3'h7, 8'hff);
      for (int p = 0; p < 2; p++) begin
         rd(3'(4*p+1), {8'hff, DIO_OUTPUT_VALUE_RST});
         rd(3'(4*p+2), {8'hff, DIO_DRIVER_TYPE_RST});
         rd(3'(4*p+3), {8'hff, DIO_UNMAPPED_READ});
         rd(3'(4*p), {8'hff, ev[p]});
      end
      for (int i = 0; i < 60; i++) begin
         sb = (i % 4 == 3);
         hw_standby <= sb;
         for (int p = 0; p < 2; p++) begin
            {dir[p], odr[p], typ[p]} = 24'($urandom);
            ev[p] <= 8'($urandom);
            ee[p] <= 8'($urandom);
            bus(1'b1, 3'(4*p), dir[p]);
            bus(1'b1, 3'(4*p+1), odr[p]);
            bus(1'b1, 3'(4*p+2), typ[p]);
         end
         idle(3);
         chk_pins();
         for (int p = 0; p < 2; p++) begin
            rd(3'(4*p+1), {8'hff, odr[p]});
            rd(3'(4*p+2), {8'hff, typ[p]});
            rd(3'(4*p), pin_note(p));
         end
      end
      idle(3);
      // Second reset mid-run: everything back to zero, pull-ups off
      resetn <= 1'b0;
      sb = 1'b1;
      for (int p = 0; p < 2; p++) begin
         {dir[p], odr[p], typ[p]} = 24'h0;
      end
      chk_pins();
      @(posedge clock);
      resetn <= 1'b1;
      hw_standby <= 1'b0;
      sb = 1'b0;
      for (int p = 0; p < 2; p++) begin
         rd(3'(4*p+1), {8'hff, DIO_OUTPUT_VALUE_RST});
         rd(3'(4*p+2), {8'hff, DIO_DRIVER_TYPE_RST});
      end
      idle(3);
      chk_pins();
      give_verdict();
   end
endmodule
